// *** dv/pgs_sequencer_sva.sv ***
// Checker for the power-up gate sequencer, bound to its top-level ports.
// Assumes pinFnField only changes while srst is high.
`timescale 1ns/1ps
module pgs_sequencer_sva
  import pgs_pkg::*;
(
  // Clock, reset and inputs
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic goodpowerPin,
  input wire logic [1:0] pinFnField,
  input wire logic lastSupplyGood,
  input wire logic cfgLoadDone,
  // Outputs watched
  input wire logic cfgLoadReq,
  input wire logic coreResetReq,
  input wire logic analogLoopEnable,
  input wire logic clkOutEnable,
  input wire logic lowPowerActive,
  input wire logic cfgFnError
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Three samples cover the synchroniser plus the edge flop
  wire pinUsed = pinFnField == PGS_FN_FIELD_SLEEP ||
    pinFnField == PGS_FN_FIELD_REBOOT;

  property p_lowpwr; lowPowerActive |-> !analogLoopEnable && !clkOutEnable;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("loop on in sleep");
  property p_pause; pinUsed && !goodpowerPin [*6] |-> !clkOutEnable;
  endproperty
  a_pause: assert property (p_pause) else $error("clock while pin low");
  property p_wake; coreResetReq && pinUsed && $rose(goodpowerPin) ##1
    goodpowerPin [*3] |-> ##[1:2] cfgLoadReq; endproperty
  a_wake: assert property (p_wake) else $error("no load on rise");
  property p_done; cfgLoadReq && cfgLoadDone && goodpowerPin |->
    ##[1:3] clkOutEnable; endproperty
  a_done: assert property (p_done) else $error("no run after load");
  property p_resume; $fell(lowPowerActive) && !$past(srst) |->
    clkOutEnable && !cfgLoadReq; endproperty
  a_resume: assert property (p_resume) else $error("bad wake");
  property p_reboot; pinFnField == PGS_FN_FIELD_REBOOT && $fell(goodpowerPin)
    ##1 !goodpowerPin [*4] |=> coreResetReq && !analogLoopEnable; endproperty
  a_reboot: assert property (p_reboot) else $error("no restart");
  property p_none; !pinUsed && !lastSupplyGood [*2] |-> !clkOutEnable;
  endproperty
  a_none: assert property (p_none) else $error("clock before supply");
  property p_both; (pinFnField == PGS_FN_FIELD_BOTH) [*2] |-> cfgFnError;
  endproperty
  a_both: assert property (p_both) else $error("both not flagged");

  c_sleep: cover property (lowPowerActive);
  c_load: cover property (cfgLoadReq && cfgLoadDone);
  c_reboot: cover property ($fell(clkOutEnable) && coreResetReq);
endmodule

bind pgs_sequencer pgs_sequencer_sva u_sva (
  .sys_clk(sys_clk), .srst(srst), .goodpowerPin(goodpowerPin),
  .pinFnField(pinFnField), .lastSupplyGood(lastSupplyGood),
  .cfgLoadDone(cfgLoadDone), .cfgLoadReq(cfgLoadReq),
  .coreResetReq(coreResetReq), .analogLoopEnable(analogLoopEnable),
  .clkOutEnable(clkOutEnable), .lowPowerActive(lowPowerActive),
  .cfgFnError(cfgFnError)
);

// *** dv/pgs_sequencer_test.sv ***
// Bench for the power-up gate sequencer: none, sleep and reboot runs.
// Assumes the supervisor model owns the pin and the loader answer.
`timescale 1ns/1ps
module pgs_sequencer_test import pgs_pkg::*;;
  logic sys_clk;
  logic srst;
  logic [1:0] pinFnField;
  logic [1:0] cfgSelPins;
  logic goodpowerPin, lastSupplyGood, cfgLoadReq, cfgLoadDone, reqQ;
  logic [1:0] cfgLoadSel;
  logic coreResetReq, analogLoopEnable, clkOutEnable, lowPowerActive;
  logic cfgFnError;
  int mismatches = 0;
  int cmpCount = 0;
  int cycles = 0;
  int loads = 0;
  wire logic [3:0] ctl = {coreResetReq, analogLoopEnable, clkOutEnable,
    lowPowerActive};
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  pgs_supervisor_model i_sup (.sys_clk(sys_clk), .cfgLoadReq(cfgLoadReq),
    .goodpowerPin(goodpowerPin), .lastSupplyGood(lastSupplyGood),
    .cfgLoadDone(cfgLoadDone));
  pgs_sequencer i_dut (.sys_clk(sys_clk), .srst(srst),
    .goodpowerPin(goodpowerPin), .pinFnField(pinFnField),
    .lastSupplyGood(lastSupplyGood), .cfgSelPins(cfgSelPins),
    .cfgLoadReq(cfgLoadReq), .cfgLoadSel(cfgLoadSel),
    .cfgLoadDone(cfgLoadDone), .coreResetReq(coreResetReq),
    .analogLoopEnable(analogLoopEnable), .clkOutEnable(clkOutEnable),
    .lowPowerActive(lowPowerActive), .cfgFnError(cfgFnError));
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    reqQ <= cfgLoadReq;
    if (cfgLoadReq === 1'b1 && reqQ !== 1'b1) loads <= loads + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Mismatches %0d of %0d compares", mismatches, cmpCount);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic restart(input logic [1:0] fn);
    @(posedge sys_clk) #1 srst = 1'b1;
    pinFnField = fn;
    loads = 0;
    i_sup.set_pin(1'b0);
    repeat (2) @(posedge sys_clk);
    #1 srst = 1'b0;
  endtask
  // Bounded wait so a stuck state shows as a mismatch, not a hang
  task automatic wait_ctl(input logic [3:0] exp);
    repeat (30) if (ctl !== exp) @(posedge sys_clk) #1;
    check(ctl, exp);
  endtask
  task automatic t_none();
    restart(PGS_FN_FIELD_NONE);
    repeat (10) @(posedge sys_clk);
    #1 check(ctl, 4'h8);
    i_sup.rails_up();
    wait_ctl(4'h6);
    restart(PGS_FN_FIELD_BOTH);
    wait_ctl(4'h6);
    check({3'h0, cfgFnError}, 4'h1);
  endtask
  task automatic t_sleep();
    cfgSelPins = 2'h2;
    restart(PGS_FN_FIELD_SLEEP);
    repeat (6) @(posedge sys_clk);
    #1 check(ctl, 4'h8);
    i_sup.set_pin(1'b1);
    wait_ctl(4'h6);
    check({2'h0, cfgLoadSel}, 4'h2);
    i_sup.set_pin(1'b0);
    wait_ctl(4'h1);
    cfgSelPins = 2'h1;
    i_sup.set_pin(1'b1);
    wait_ctl(4'h6);
    check({2'h0, cfgLoadSel}, 4'h2);
    check(loads[3:0], 4'h1);
  endtask
  task automatic t_reboot();
    cfgSelPins = 2'h1;
    restart(PGS_FN_FIELD_REBOOT);
    i_sup.loadWait = 6;
    i_sup.rails_up();
    wait_ctl(4'h6);
    i_sup.set_pin(1'b0);
    wait_ctl(4'h8);
    cfgSelPins = 2'h3;
    i_sup.set_pin(1'b1);
    wait_ctl(4'h6);
    check({2'h0, cfgLoadSel}, 4'h3);
    check(loads[3:0], 4'h2);
    // One-cycle low pulse: restart must still reload once the pin is high
    i_sup.set_pin(1'b0);
    i_sup.set_pin(1'b1);
    repeat (3) @(posedge sys_clk);
    #1 check(ctl, 4'h8);
    wait_ctl(4'h6);
    check(loads[3:0], 4'h3);
  endtask
  // Pin dropped while the first load is still running
  task automatic t_late_drop();
    restart(PGS_FN_FIELD_SLEEP);
    i_sup.loadWait = 6;
    i_sup.set_pin(1'b1);
    repeat (4) @(posedge sys_clk);
    i_sup.set_pin(1'b0);
    wait_ctl(4'h1);
    i_sup.set_pin(1'b1);
    wait_ctl(4'h6);
    check(loads[3:0], 4'h1);
  endtask
  initial begin
    srst = 1'b1;
    pinFnField = PGS_FN_FIELD_NONE;
    cfgSelPins = 2'h0;
    t_none();
    t_sleep();
    t_reboot();
    t_late_drop();
    report_and_stop();
  end
endmodule

// *** dv/pgs_supervisor_model.sv ***
// Board supervisor and configuration loader facing the sequencer.
// Assumes the bench calls its tasks; pin moves 1 ns after an edge.
`timescale 1ns/1ps
module pgs_supervisor_model #(
  parameter int HOLD_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic cfgLoadReq,
  output logic goodpowerPin,
  output logic lastSupplyGood,
  output logic cfgLoadDone
);
  int loadWait = 1;
  int cnt = 0;
  initial begin
    goodpowerPin = 1'b0;
    lastSupplyGood = 1'b0;
    cfgLoadDone = 1'b0;
  end
  task automatic rails_up();
    @(posedge sys_clk) #1 lastSupplyGood = 1'b1;
    repeat (HOLD_CYC) @(posedge sys_clk);
    #1 goodpowerPin = lastSupplyGood;
  endtask
  task automatic set_pin(input logic v);
    @(posedge sys_clk) #1 goodpowerPin = v;
  endtask
  // Slow loaders are modelled by raising loadWait
  always @(posedge sys_clk) begin
    cnt <= cfgLoadReq ? cnt + 1 : 0;
    cfgLoadDone <= cfgLoadReq && cnt >= loadWait;
  end
endmodule

// *** hw/pgs_pin_if.sv ***
// Interface carrying the synchronised power-control pin and its edges.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface pgs_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// *** hw/pgs_pin_sync.sv ***
// Two-stage synchroniser and edge detector for the power-control pin.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ps
module pgs_pin_sync
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Raw pin
  input wire logic pinRaw,
  // Synchronised view
  pgs_pin_if.src pin
);
  logic meta_ff;
  logic stable_ff;
  logic last_ff;

  ////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_ff <= PGS_PIN_RESET_LEVEL;
      stable_ff <= PGS_PIN_RESET_LEVEL;
    end else begin
      meta_ff <= pinRaw;
      stable_ff <= meta_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_ff <= PGS_PIN_RESET_LEVEL;
    end else begin
      last_ff <= stable_ff;
    end
  end

  // Each level change yields exactly one edge pulse
  assign pin.level = stable_ff;
  assign pin.rise = stable_ff & ~last_ff;
  assign pin.fall = ~stable_ff & last_ff;
endmodule

// *** hw/pgs_pkg.sv ***
// Package for the power-up gate sequencer: pin functions, states, widths.
// Assumes a single sys_clk domain at 200 MHz.
package pgs_pkg;
  // Pin function selected by the stored configuration
  typedef enum logic [1:0] {
    PGS_FN_NONE,
    PGS_FN_SLEEP,
    PGS_FN_REBOOT
  } pgs_fn_e;

  typedef enum logic [2:0] {
    PGS_ST_WAIT_SUPPLY,
    PGS_ST_PAUSED,
    PGS_ST_LOAD,
    PGS_ST_RUN,
    PGS_ST_SLEEP,
    PGS_ST_RESTART
  } pgs_state_e;

  localparam int PGS_CFG_SEL_W = 2;
  localparam int PGS_SYNC_STAGES = 2;
  localparam logic [1:0] PGS_FN_FIELD_NONE = 2'h0;
  localparam logic [1:0] PGS_FN_FIELD_SLEEP = 2'h1;
  localparam logic [1:0] PGS_FN_FIELD_REBOOT = 2'h2;
  localparam logic [1:0] PGS_FN_FIELD_BOTH = 2'h3;
  localparam logic PGS_PIN_RESET_LEVEL = 1'b0;
endpackage

// *** hw/pgs_sequencer.sv ***
// Power-up gate sequencer: drives start-up, load, sleep and restart
// controls from the single power-control pin.
// Assumes configuration fields are stable while the pin is low.
//
// Function
// - Sleep and restart variants: pin low pauses start-up; sequence continues only once pin goes high.
// - Sleep variant: first high loads a configuration chosen by select pins.
// - Sleep variant: later highs restore the earlier configuration, no load.
// - Sleep variant: low enters or keeps low power, analog loop off.
// - Leaving low power resumes the operating state held before.
// - Restart variant: low resets device to redo whole power-up.
// - Restart variant: next high loads a configuration afresh.
// - A configuration gives the pin one function, never both.
// - No pin function: clocks gated until last supply is valid.
`timescale 1ns/1ps
module pgs_sequencer
  import pgs_pkg::*;
#(
  parameter int CFG_SEL_W = PGS_CFG_SEL_W
) (
  // Clock and reset (reset models the internal power-on reset)
  input wire logic sys_clk,
  input wire logic srst,
  // Power-control pin, raw from the board
  input wire logic goodpowerPin,
  // Stored configuration: pin function field and supply status
  input wire logic [1:0] pinFnField,
  input wire logic lastSupplyGood,
  input wire logic [CFG_SEL_W-1:0] cfgSelPins,
  // Configuration loader handshake
  output logic cfgLoadReq,
  output logic [CFG_SEL_W-1:0] cfgLoadSel,
  input wire logic cfgLoadDone,
  // Controls to the rest of the device
  output logic coreResetReq,
  output logic analogLoopEnable,
  output logic clkOutEnable,
  output logic lowPowerActive,
  output logic cfgFnError
);
  pgs_pin_if pinBus();
  pgs_state_e state_ff;
  pgs_state_e nxt_state;
  pgs_state_e resume_ff;
  logic loaded_ff;
  logic [CFG_SEL_W-1:0] sel_ff;
  logic lowLevel;
  logic loadDue;
  pgs_fn_e fn;

  // Decodes the configuration field; both functions at once is refused
  function automatic pgs_fn_e decode_fn(input logic [1:0] field);
    case (field)
      PGS_FN_FIELD_SLEEP: decode_fn = PGS_FN_SLEEP;
      PGS_FN_FIELD_REBOOT: decode_fn = PGS_FN_REBOOT;
      default: decode_fn = PGS_FN_NONE;
    endcase
  endfunction

  pgs_pin_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pinRaw(goodpowerPin),
    .pin(pinBus.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Function decode
  assign fn = decode_fn(pinFnField);
  assign lowLevel = ~pinBus.level;
  // Sleep variant loads only once; restart always loads
  assign loadDue = (fn != PGS_FN_SLEEP) | ~loaded_ff;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PGS_ST_WAIT_SUPPLY: begin
        // Without a pin function only the supplies gate start-up
        if (fn == PGS_FN_NONE) begin
          if (lastSupplyGood) begin
            nxt_state = PGS_ST_LOAD;
          end
        end else begin
          nxt_state = PGS_ST_PAUSED;
        end
      end
      PGS_ST_PAUSED: begin
        // Level, not edge: a short restart pulse may already be over here
        if (pinBus.level) begin
          nxt_state = loadDue ? PGS_ST_LOAD : resume_ff;
        end
      end
      PGS_ST_LOAD: begin
        // Sleep variant pin dropped during the load: never show clocks
        if (cfgLoadDone && fn == PGS_FN_SLEEP && lowLevel) begin
          nxt_state = PGS_ST_SLEEP;
        end else if (cfgLoadDone) begin
          nxt_state = PGS_ST_RUN;
        end
      end
      PGS_ST_RUN, PGS_ST_SLEEP: begin
        if (fn == PGS_FN_SLEEP && lowLevel) begin
          nxt_state = PGS_ST_SLEEP;
        end else if (fn == PGS_FN_SLEEP && pinBus.rise) begin
          nxt_state = resume_ff;
        end else if (fn == PGS_FN_REBOOT && pinBus.fall) begin
          nxt_state = PGS_ST_RESTART;
        end
      end
      PGS_ST_RESTART: begin
        nxt_state = PGS_ST_PAUSED;
      end
      default: nxt_state = PGS_ST_WAIT_SUPPLY;
    endcase
    // Restart-variant load may be cut short by the pin falling again
    if (state_ff == PGS_ST_LOAD && fn == PGS_FN_REBOOT && pinBus.fall) begin
      nxt_state = PGS_ST_RESTART;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= PGS_ST_WAIT_SUPPLY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Operating state to return to after low power
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resume_ff <= PGS_ST_RUN;
    end else if (state_ff == PGS_ST_RUN) begin
      resume_ff <= PGS_ST_RUN;
    end
  end

  // Tracks whether a configuration was loaded since reset or the last restart
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      loaded_ff <= 1'b0;
    end else if (state_ff == PGS_ST_RESTART) begin
      loaded_ff <= 1'b0;
    end else if (state_ff == PGS_ST_LOAD && cfgLoadDone) begin
      loaded_ff <= 1'b1;
    end
  end

  // Select pins sampled when the load starts so they may move afterwards
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_ff <= '0;
    end else if (state_ff != PGS_ST_LOAD && nxt_state == PGS_ST_LOAD) begin
      sel_ff <= cfgSelPins;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs but cfgFnError and cfgLoadSel, registered from the next state so they move with the state

  // Loader request stands for the whole load
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfgLoadReq <= 1'b0;
    end else begin
      cfgLoadReq <= (nxt_state == PGS_ST_LOAD);
    end
  end

  // Core held in reset while start-up is paused or restarting
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      coreResetReq <= 1'b1;
    end else begin
      coreResetReq <= (nxt_state == PGS_ST_WAIT_SUPPLY) ||
                      (nxt_state == PGS_ST_PAUSED) ||
                      (nxt_state == PGS_ST_RESTART);
    end
  end

  // Analog loop runs only while loading or running; off in sleep
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      analogLoopEnable <= 1'b0;
    end else begin
      analogLoopEnable <= (nxt_state == PGS_ST_LOAD) ||
                          (nxt_state == PGS_ST_RUN);
    end
  end

  // Clocks stay gated in every state but RUN
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clkOutEnable <= 1'b0;
    end else begin
      clkOutEnable <= (nxt_state == PGS_ST_RUN);
    end
  end

  // Low-power flag follows the sleep state alone
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lowPowerActive <= 1'b0;
    end else begin
      lowPowerActive <= (nxt_state == PGS_ST_SLEEP);
    end
  end

  // Illegal field is flagged; it still decodes as no pin function
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfgFnError <= 1'b0;
    end else begin
      cfgFnError <= (pinFnField == PGS_FN_FIELD_BOTH);
    end
  end

  assign cfgLoadSel = sel_ff;
endmodule
